// *** hdl/csr_pkg.sv ***
// Contract
// [R1] Run bit high makes the timer count down; low stops it.
// [R2] Writing reload high loads the timer; the bit clears itself after loading.
// [R3] Prescale bit: timer ticks at CPU clock /16 when 0, /2 when 1.
// [R4] Shared interrupt pin is an input when direction bit is 0, output when 1.
// [R5] Clock output disable set releases the clock output pin.
// [R6] Remote lockout set refuses every remote access.
// [R7] Global enable low blocks all maskable interrupts; high defers to masks.
// [R8] Twinax modes: bits 2..0 station address, bits 7..3 hold time, 0.5 us steps.
// [R9] Eight-bit modes: all eight bits form the station address.
// [R10] Expired flag sets at zero; cleared by writing 1 or clearing run.
// [R11] Remote read/write flags set at strobe end if enabled and data memory.
// [R12] Read-only bit mirrors the shared interrupt pin, resampled per instruction.
// [R13] Sign, zero and overflow flags follow instruction results.
// [R14] Carry records carry or borrow, or last bit shifted out.
// [R15] CPU clock divider: full rate when 0, half when 1.
// [R16] Link clock select: full, half, quarter, or external link clock.
// [R17] Two-bit code fetch waits 0..3, three-bit data memory waits 0..7.
// [R18] Stack port pushes and pops a sixteen-entry byte stack.
// [R19] Error view select maps the error code register onto the FIFO location.
// [R20] Overrun sets on frame with three words held; errors clear on read or reset.
// [R21] Flag odd word parity and bad closing sequence.
// [R22] Flag lost mid-bit edge and preemption without receive-during-transmit.
// [R23] Each mask bit set suppresses its interrupt, combined with global enable.
// [R24] Link reset control holds the transceiver in reset and clears errors.
// [R25] Writing 0 leaves write-one-clear flags; reserved bits ignore writes.
package csr_pkg;
    // Main bank register numbers.
    localparam logic [4:0] MAIN_CONDITION = 5'h00;
    localparam logic [4:0] MAIN_AUX_CONTROL = 5'h03;
    localparam logic [4:0] MAIN_STACK_PORT = 5'h1F;
    // Alternate bank register numbers.
    localparam logic [4:0] ALT_CLOCKING = 5'h00;
    localparam logic [4:0] ALT_LINK_SETUP = 5'h02;
    localparam logic [4:0] ALT_FILL_BITS = 5'h03;
    localparam logic [4:0] ALT_FIFO_PORT = 5'h04;
    // Auxiliary control fields.
    localparam int ACR_RUN = 7;
    localparam int ACR_RELOAD = 6;
    localparam int ACR_PRESCALE = 5;
    localparam int ACR_IRQ_DIR = 4;
    localparam int ACR_CLK_OFF = 2;
    localparam int ACR_LOCKOUT = 1;
    localparam int ACR_GIE = 0;
    localparam logic [7:0] ACR_WMASK = 8'hF7;
    // Condition flag fields.
    localparam int CCR_EXPIRED = 7;
    localparam int CCR_RREAD = 6;
    localparam int CCR_RWRITE = 5;
    localparam int CCR_PIN = 4;
    localparam int CCR_NEG = 3;
    localparam int CCR_OVF = 2;
    localparam int CCR_CARRY = 1;
    localparam int CCR_ZERO = 0;
    // Error code fields.
    localparam int ECR_OVERRUN = 4;
    localparam int ECR_PARITY = 3;
    localparam int ECR_BADEND = 2;
    localparam int ECR_MIDBIT = 1;
    localparam int ECR_PREEMPT = 0;
    // Reset values.
    localparam logic [7:0] ACR_RESET = 8'h00;
    localparam logic [7:0] ATR_RESET = 8'h00;
    localparam logic [7:0] DCR_RESET = 8'h00;
    localparam logic [7:0] FBR_RESET = 8'h00;
    // Prescale divides, hold-time step, stack depth and full receive count.
    localparam int PRESCALE_SLOW = 16;
    localparam int PRESCALE_FAST = 2;
    localparam int HOLD_STEP_NS = 500;
    localparam int CLK_PERIOD_NS = 5;
    localparam int HOLD_STEP_CYC = HOLD_STEP_NS / CLK_PERIOD_NS;
    localparam int STACK_DEPTH = 16;
    localparam int RX_FULL_WORDS = 3;
endpackage

// *** hdl/csr_special_regs.sv ***
module csr_special_regs #(
    parameter int STACK_DEPTH = csr_pkg::STACK_DEPTH,
    parameter int TIMER_WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    // CPU register-file access: bank 0 main, 1 alternate.
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic regBank,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // FIFO data that the transceiver shows at the FIFO location.
    input wire logic [7:0] fifoRdData,
    input wire logic errorViewSelect,
    input wire logic linkResetControl,
    input wire logic eightBitMode,
    // Timer interface: current value and load value.
    input wire logic [TIMER_WIDTH-1:0] timerLoadValue,
    output logic [TIMER_WIDTH-1:0] timerValue,
    // CPU core result flags.
    input wire logic instrStart,
    input wire logic aluFlagsValid,
    input wire logic aluNegative,
    input wire logic aluZero,
    input wire logic aluOvfValid,
    input wire logic aluOverflow,
    input wire logic aluCarryValid,
    input wire logic aluCarry,
    // Interrupt gating.
    input wire logic [4:0] irqRequests,
    input wire logic [4:0] irqMaskBits,
    output logic [4:0] irqGated,
    // Shared interrupt pin, four signals.
    input wire logic sharedIrqPinIn,
    input wire logic sharedIrqLevel,
    output logic sharedIrqPinOut,
    output logic sharedIrqPinOe,
    // Clock output pin.
    input wire logic cpuClkIn,
    output logic clockOutPin,
    output logic clockOutOe,
    // Remote side strobes (asynchronous pins).
    input wire logic remoteReadStrobe,
    input wire logic remoteWriteStrobe,
    input wire logic remoteAccessEnable,
    input wire logic remoteCfgDataMem,
    output logic remoteAccessGrant,
    // Receive error events (one-cycle pulses) and their level qualifiers.
    input wire logic rxFrameDone,
    input wire logic [1:0] rxWordsHeld,
    input wire logic rxParityOdd,
    input wire logic rxBadEnd,
    input wire logic rxMidbitLost,
    input wire logic txStart,
    input wire logic rxActive,
    input wire logic rxDuringTxEnable,
    output logic linkReset,
    // Decoded settings.
    output logic [7:0] rxStationAddr,
    output logic [4:0] txHoldSteps,
    output logic [15:0] txHoldCycles,
    output logic cpuClockDivider,
    output logic [1:0] linkClockSelect,
    output logic [1:0] codeFetchWaits,
    output logic [2:0] operandMemWaits,
    output logic [7:0] fillBitPattern,
    output logic stackOverflow,
    output logic stackUnderflow
);
    logic [7:0] acr_q;
    logic [7:0] atr_q;
    logic [7:0] dcr_q;
    logic [7:0] fbr_q;
    logic expired_q;
    logic rread_q;
    logic rwrite_q;
    logic pin_q;
    logic neg_q;
    logic ovf_q;
    logic carry_q;
    logic zero_q;
    logic [4:0] err_q;
    logic [TIMER_WIDTH-1:0] timer_q;
    logic [3:0] pre_q;
    logic [7:0] stack_q [STACK_DEPTH];
    logic [$clog2(STACK_DEPTH):0] sp_q;
    logic pinSync1_q;
    logic pinSync2_q;
    logic rdSync1_q;
    logic rdSync2_q;
    logic rdSync3_q;
    logic wrSync1_q;
    logic wrSync2_q;
    logic wrSync3_q;

    function automatic logic hit(input logic bank, input logic [4:0] addr);
        hit = (regBank == bank) && (regAddr == addr);
    endfunction

    logic wrAcr;
    logic wrCcr;
    logic wrAtr;
    logic wrDcr;
    logic wrFbr;
    logic wrStack;
    logic rdStack;
    logic rdErr;
    assign wrAcr = regWrEn && hit(1'b0, csr_pkg::MAIN_AUX_CONTROL);
    assign wrCcr = regWrEn && hit(1'b0, csr_pkg::MAIN_CONDITION);
    assign wrStack = regWrEn && hit(1'b0, csr_pkg::MAIN_STACK_PORT);
    assign rdStack = regRdEn && hit(1'b0, csr_pkg::MAIN_STACK_PORT);
    assign wrDcr = regWrEn && hit(1'b1, csr_pkg::ALT_CLOCKING);
    assign wrAtr = regWrEn && hit(1'b1, csr_pkg::ALT_LINK_SETUP);
    assign wrFbr = regWrEn && hit(1'b1, csr_pkg::ALT_FILL_BITS);
    assign rdErr = regRdEn && errorViewSelect // R19
        && hit(1'b1, csr_pkg::ALT_FIFO_PORT);

    // Reload clears itself once the load has happened, so only the load
    // cycle that follows the write cycle sees it set.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            acr_q <= csr_pkg::ACR_RESET;
        else if (wrAcr)
            acr_q <= regWrData & csr_pkg::ACR_WMASK; // R25
        else if (acr_q[csr_pkg::ACR_RELOAD])
            acr_q[csr_pkg::ACR_RELOAD] <= 1'b0; // R2
    end

    logic run, tick, timerZero;
    assign run = acr_q[csr_pkg::ACR_RUN];
    assign tick = acr_q[csr_pkg::ACR_PRESCALE]
        ? (pre_q[0] == 1'b1) // R3
        : (pre_q == 4'hF);
    assign timerZero = (timer_q == '0);

    always_ff @(posedge ref_clk)
    begin
        if (rst || !run)
            pre_q <= 4'h0;
        else
            pre_q <= pre_q + 4'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            timer_q <= '0;
        else if (acr_q[csr_pkg::ACR_RELOAD])
            timer_q <= timerLoadValue; // R2
        else if (run && tick && !timerZero)
            timer_q <= timer_q - 1'b1; // R1
    end
    assign timerValue = timer_q;

    // A reload in the same cycle as the last tick must not flag expiry,
    // because the count restarts instead of reaching zero.
    logic timerHitZero;
    assign timerHitZero = run && tick && (timer_q == 1)
        && !acr_q[csr_pkg::ACR_RELOAD]; // R10

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            expired_q <= 1'b0;
        else if (timerHitZero)
            expired_q <= 1'b1; // R10
        else if (wrAcr && !regWrData[csr_pkg::ACR_RUN])
            expired_q <= 1'b0; // R10
        else if (wrCcr && regWrData[csr_pkg::CCR_EXPIRED])
            expired_q <= 1'b0; // R25
    end

    // Remote strobes are pins: two stages, then a third for edge detection.
    always_ff @(posedge ref_clk)
    begin
        rdSync1_q <= remoteReadStrobe;
        rdSync2_q <= rdSync1_q;
        rdSync3_q <= rdSync2_q;
        wrSync1_q <= remoteWriteStrobe;
        wrSync2_q <= wrSync1_q;
        wrSync3_q <= wrSync2_q;
        pinSync1_q <= sharedIrqPinIn;
        pinSync2_q <= pinSync1_q;
    end

    logic remoteOk;
    logic rdTrail;
    logic wrTrail;
    assign remoteAccessGrant = !acr_q[csr_pkg::ACR_LOCKOUT]; // R6
    assign remoteOk = remoteAccessGrant && remoteAccessEnable
        && remoteCfgDataMem;
    assign rdTrail = rdSync3_q && !rdSync2_q;
    assign wrTrail = wrSync3_q && !wrSync2_q;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rread_q <= 1'b0;
        else if (remoteOk && rdTrail)
            rread_q <= 1'b1; // R11
        else if (wrCcr && regWrData[csr_pkg::CCR_RREAD])
            rread_q <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rwrite_q <= 1'b0;
        else if (remoteOk && wrTrail)
            rwrite_q <= 1'b1; // R11
        else if (wrCcr && regWrData[csr_pkg::CCR_RWRITE])
            rwrite_q <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            pin_q <= 1'b0;
        else if (instrStart)
            pin_q <= pinSync2_q; // R12
    end

    // Software writes win only when the core is not updating flags.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            neg_q <= 1'b0;
            zero_q <= 1'b0;
        end
        else if (aluFlagsValid)
        begin
            neg_q <= aluNegative; // R13
            zero_q <= aluZero; // R13
        end
        else if (wrCcr)
        begin
            neg_q <= regWrData[csr_pkg::CCR_NEG];
            zero_q <= regWrData[csr_pkg::CCR_ZERO];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ovf_q <= 1'b0;
        else if (aluOvfValid)
            ovf_q <= aluOverflow; // R13
        else if (wrCcr)
            ovf_q <= regWrData[csr_pkg::CCR_OVF];
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            carry_q <= 1'b0;
        else if (aluCarryValid)
            carry_q <= aluCarry; // R14
        else if (wrCcr)
            carry_q <= regWrData[csr_pkg::CCR_CARRY];
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            atr_q <= csr_pkg::ATR_RESET;
            dcr_q <= csr_pkg::DCR_RESET;
            fbr_q <= csr_pkg::FBR_RESET;
        end
        else
        begin
            if (wrAtr)
                atr_q <= regWrData;
            if (wrDcr)
                dcr_q <= regWrData;
            if (wrFbr)
                fbr_q <= regWrData;
        end
    end

    assign rxStationAddr = eightBitMode ? atr_q // R9
        : {5'h00, atr_q[2:0]}; // R8
    assign txHoldSteps = eightBitMode ? 5'h00 : atr_q[7:3]; // R8
    assign txHoldCycles = 16'(txHoldSteps * csr_pkg::HOLD_STEP_CYC); // R8
    assign cpuClockDivider = dcr_q[7]; // R15
    assign linkClockSelect = dcr_q[6:5]; // R16
    assign codeFetchWaits = dcr_q[4:3]; // R17
    assign operandMemWaits = dcr_q[2:0]; // R17
    assign fillBitPattern = fbr_q;

    // Receive errors: set wins over the read clear, link reset clears all.
    logic [4:0] errSet;
    assign errSet = {
        rxFrameDone && (rxWordsHeld == 2'(csr_pkg::RX_FULL_WORDS)), // R20
        rxParityOdd, // R21
        rxBadEnd, // R21
        rxMidbitLost, // R22
        txStart && rxActive && !rxDuringTxEnable}; // R22
    assign linkReset = linkResetControl || rst; // R24

    always_ff @(posedge ref_clk)
    begin
        if (linkReset)
            err_q <= 5'h00; // R24
        else
            err_q <= errSet | (rdErr ? 5'h00 : err_q); // R20
    end

    // Data stack; overflow and underflow are reported, not stored.
    logic stackFull, stackEmpty;
    assign stackFull = (sp_q == ($clog2(STACK_DEPTH)+1)'(STACK_DEPTH));
    assign stackEmpty = (sp_q == '0);
    assign stackOverflow = wrStack && stackFull;
    assign stackUnderflow = rdStack && stackEmpty;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            sp_q <= '0;
        else if (wrStack && !stackFull)
            sp_q <= sp_q + 1'b1; // R18
        else if (rdStack && !stackEmpty)
            sp_q <= sp_q - 1'b1; // R18
    end

    always_ff @(posedge ref_clk)
    begin
        if (wrStack && !stackFull)
            stack_q[sp_q[$clog2(STACK_DEPTH)-1:0]] <= regWrData;
    end

    logic [7:0] stackTop;
    assign stackTop = stackEmpty ? 8'h00
        : stack_q[$clog2(STACK_DEPTH)'(sp_q - 1'b1)];

    // Interrupt gating.
    assign irqGated = acr_q[csr_pkg::ACR_GIE] // R7
        ? (irqRequests & ~irqMaskBits) : 5'h00; // R23

    // Shared pin and clock output.
    assign sharedIrqPinOe = acr_q[csr_pkg::ACR_IRQ_DIR]; // R4
    assign sharedIrqPinOut = sharedIrqLevel;
    assign clockOutOe = !acr_q[csr_pkg::ACR_CLK_OFF]; // R5
    assign clockOutPin = cpuClkIn;

    always_comb
    begin
        regRdData = 8'h00;
        if (regBank == 1'b0)
        begin
            case (regAddr)
                csr_pkg::MAIN_CONDITION: regRdData = {expired_q, rread_q,
                    rwrite_q, pin_q, neg_q, ovf_q, carry_q, zero_q};
                csr_pkg::MAIN_AUX_CONTROL: regRdData = acr_q;
                csr_pkg::MAIN_STACK_PORT: regRdData = stackTop;
                default: regRdData = 8'h00;
            endcase
        end
        else
        begin
            case (regAddr)
                csr_pkg::ALT_CLOCKING: regRdData = dcr_q;
                csr_pkg::ALT_LINK_SETUP: regRdData = atr_q;
                csr_pkg::ALT_FILL_BITS: regRdData = fbr_q;
                csr_pkg::ALT_FIFO_PORT: regRdData = errorViewSelect
                    ? {3'h0, err_q} : fifoRdData; // R19
                default: regRdData = 8'h00;
            endcase
        end
    end
endmodule

// *** tb/csr_regs_chk.sv ***
module csr_regs_chk #(
    parameter int TIMER_WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic regBank,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic [7:0] fifoRdData,
    input wire logic errorViewSelect,
    input wire logic eightBitMode,
    input wire logic [TIMER_WIDTH-1:0] timerLoadValue,
    input wire logic [TIMER_WIDTH-1:0] timerValue,
    input wire logic [4:0] irqMaskBits,
    input wire logic [4:0] irqGated,
    input wire logic sharedIrqPinOe,
    input wire logic remoteAccessGrant,
    input wire logic [7:0] rxStationAddr,
    input wire logic [4:0] txHoldSteps,
    input wire logic cpuClockDivider,
    input wire logic [1:0] linkClockSelect,
    input wire logic [1:0] codeFetchWaits,
    input wire logic [2:0] operandMemWaits
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire wrAux = regWrEn && !regBank
        && regAddr == csr_pkg::MAIN_AUX_CONTROL;
    wire wrClk = regWrEn && regBank && regAddr == csr_pkg::ALT_CLOCKING;
    wire wrLnk = regWrEn && regBank && regAddr == csr_pkg::ALT_LINK_SETUP;
    property p_dir; wrAux |=> sharedIrqPinOe == $past(regWrData[4]); endproperty
    a_dir: assert property (p_dir) else $error("irq pin direction");
    property p_lock; wrAux |=> remoteAccessGrant == !$past(regWrData[1]);
    endproperty
    a_lock: assert property (p_lock) else $error("remote lockout");
    // The reload bit is registered first, so the count loads one edge later.
    property p_load;
        wrAux && regWrData[6] |=> ##1 timerValue == $past(timerLoadValue);
    endproperty
    a_load: assert property (p_load) else $error("timer load");
    property p_mask; (irqGated & irqMaskBits) == 5'h00; endproperty
    a_mask: assert property (p_mask) else $error("masked irq passed");
    property p_gie; wrAux && !regWrData[0] |=> irqGated == 5'h00;
    endproperty
    a_gie: assert property (p_gie) else $error("global irq enable");
    property p_dcr; wrClk |=> {cpuClockDivider, linkClockSelect,
        codeFetchWaits, operandMemWaits} == $past(regWrData); endproperty
    a_dcr: assert property (p_dcr) else $error("clocking");
    property p_atr; wrLnk && !eightBitMode ##1 !eightBitMode |->
        {txHoldSteps, rxStationAddr[2:0]} == $past(regWrData); endproperty
    a_atr: assert property (p_atr) else $error("twinax setup");
    property p_atr8; wrLnk && eightBitMode ##1 eightBitMode |->
        rxStationAddr == $past(regWrData); endproperty
    a_atr8: assert property (p_atr8) else $error("station addr");
    property p_fifo; regRdEn && regBank && regAddr == csr_pkg::ALT_FIFO_PORT
        && !errorViewSelect |-> regRdData == fifoRdData; endproperty
    a_fifo: assert property (p_fifo) else $error("fifo view");
endmodule

bind csr_special_regs csr_regs_chk #(.TIMER_WIDTH(TIMER_WIDTH))
    csr_regs_chk_i (.*);

// *** tb/csr_remote_host.sv ***
module csr_remote_host (
    input wire logic ref_clk,
    input wire logic rdReq,
    input wire logic wrReq,
    input wire logic [3:0] holdCycles,
    output logic remoteReadStrobe,
    output logic remoteWriteStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Strobes rest low between accesses; width sets a prompt or slow host.
    initial
    begin
        remoteReadStrobe = 1'b0;
        remoteWriteStrobe = 1'b0;
        forever
        begin
            @(posedge ref_clk);
            if (rdReq || wrReq)
            begin
                remoteReadStrobe <= rdReq;
                remoteWriteStrobe <= wrReq;
                repeat (holdCycles) @(posedge ref_clk);
                remoteReadStrobe <= 1'b0;
                remoteWriteStrobe <= 1'b0;
            end
        end
    end
endmodule

// *** tb/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] AUX = csr_pkg::MAIN_AUX_CONTROL;
    localparam logic [4:0] CND = csr_pkg::MAIN_CONDITION;
    localparam logic [4:0] FIFO = csr_pkg::ALT_FIFO_PORT;
    logic ref_clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
    logic regBank = 1'b0, errorViewSelect = 1'b0, linkResetControl = 1'b0;
    logic eightBitMode = 1'b0, rxActive = 1'b1, rxDuringTxEnable = 1'b0;
    logic remoteAccessEnable = 1'b1, remoteCfgDataMem = 1'b1;
    logic aluNegative = 1'b1, aluZero = 1'b0, aluOverflow = 1'b1;
    logic aluCarry = 1'b1, sharedIrqPinIn = 1'b0;
    logic sharedIrqLevel = 1'b0, cpuClkIn = 1'b0;
    logic [4:0] regAddr = 5'h00, irqRequests = 5'h1F, irqMaskBits = 5'h03;
    logic [7:0] regWrData = 8'h00, fifoRdData = 8'h5A;
    logic [15:0] timerLoadValue = 16'h0003;
    logic [1:0] rxWordsHeld = 2'h3;
    logic [3:0] holdCycles = 4'h2;
    logic [10:0] ev = 11'h000;
    logic [7:0] pat [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
    wire rxFrameDone, rxParityOdd, rxBadEnd, rxMidbitLost, txStart;
    wire instrStart, aluFlagsValid, aluOvfValid, aluCarryValid;
    wire rdReq, wrReq, remoteReadStrobe, remoteWriteStrobe;
    logic [7:0] regRdData, rxStationAddr, fillBitPattern, rd;
    logic [15:0] timerValue, txHoldCycles;
    logic [4:0] irqGated, txHoldSteps;
    logic [2:0] operandMemWaits;
    logic [1:0] linkClockSelect, codeFetchWaits;
    logic sharedIrqPinOut, sharedIrqPinOe, clockOutPin, clockOutOe, linkReset;
    logic remoteAccessGrant, cpuClockDivider, stackOverflow, stackUnderflow;
    logic ovf, unf;
    int mismatches = 0;
    int num_checks = 0;
    assign {rxFrameDone, rxParityOdd, rxBadEnd, rxMidbitLost, txStart,
        instrStart, aluFlagsValid, aluOvfValid, aluCarryValid, rdReq,
        wrReq} = ev;
    csr_special_regs csr_special_regs_i (.*);
    csr_remote_host csr_remote_host_i (.*);
    initial forever #2.5 ref_clk = ~ref_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Read data and stack flags are combinational, so they are taken
    // inside the access cycle, before the edge that pops or clears.
    task automatic acc(input logic w, input logic b, input logic [4:0] a,
        input logic [7:0] d);
        @(posedge ref_clk);
        regWrEn <= w;
        regRdEn <= !w;
        regBank <= b;
        regAddr <= a;
        regWrData <= d;
        #1;
        rd = regRdData;
        ovf = stackOverflow;
        unf = stackUnderflow;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        regRdEn <= 1'b0;
        #1;
    endtask

    task automatic pulse(input logic [10:0] v);
        @(posedge ref_clk);
        ev <= v;
        @(posedge ref_clk);
        ev <= 11'h000;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        acc(0, 0, AUX, 8'h00);
        chk(rd, csr_pkg::ACR_RESET);
        acc(0, 1, 5'h1E, 8'h00);
        chk(rd, 8'h00);
        acc(1, 0, AUX, 8'h1F);
        acc(0, 0, AUX, 8'h00);
        chk(rd, 8'h17);
        chk(sharedIrqPinOe, 1'b1);
        chk(clockOutOe, 1'b0);
        chk(remoteAccessGrant, 1'b0);
        chk(irqGated, 5'h1C);
        acc(1, 0, AUX, 8'h10);
        chk(irqGated, 5'h00);
        chk(clockOutOe, 1'b1);
        foreach (pat[i])
        begin
            acc(1, 1, csr_pkg::ALT_CLOCKING, pat[i]);
            chk({cpuClockDivider, linkClockSelect, codeFetchWaits,
                operandMemWaits}, pat[i]);
        end
        acc(1, 1, csr_pkg::ALT_LINK_SETUP, 8'hFD);
        chk(txHoldCycles, 16'h0C1C);
        chk(rxStationAddr, 8'h05);
        @(posedge ref_clk) eightBitMode <= 1'b1;
        acc(1, 1, csr_pkg::ALT_LINK_SETUP, 8'hFD);
        chk(rxStationAddr, 8'hFD);
        acc(1, 1, csr_pkg::ALT_FILL_BITS, 8'h3C);
        chk(fillBitPattern, 8'h3C);
        acc(0, 1, csr_pkg::ALT_FILL_BITS, 8'h00);
        chk(rd, 8'h3C);
        $display("control and settings test done");
        acc(1, 0, AUX, 8'hE0);
        acc(0, 0, AUX, 8'h00);
        chk(rd, 8'hA0);
        repeat (12) @(posedge ref_clk);
        chk(timerValue, 16'h0000);
        acc(1, 0, CND, 8'h00);
        acc(0, 0, CND, 8'h00);
        chk(rd[7], 1'b1);
        acc(1, 0, CND, 8'h80);
        acc(0, 0, CND, 8'h00);
        chk(rd[7], 1'b0);
        // The prescaler may only change while the timer is stopped.
        acc(1, 0, AUX, 8'h00);
        @(posedge ref_clk) timerLoadValue <= 16'h0002;
        acc(1, 0, AUX, 8'hC0);
        repeat (8) @(posedge ref_clk);
        chk(timerValue, 16'h0002);
        repeat (40) @(posedge ref_clk);
        acc(0, 0, CND, 8'h00);
        chk(rd[7], 1'b1);
        acc(1, 0, AUX, 8'h00);
        acc(0, 0, CND, 8'h00);
        chk({timerValue, rd[7]}, 17'h00000);
        $display("timer test done");
        for (int i = 0; i < csr_pkg::STACK_DEPTH; i++)
            acc(1, 0, csr_pkg::MAIN_STACK_PORT, 8'(i));
        acc(1, 0, csr_pkg::MAIN_STACK_PORT, 8'hEE);
        chk(ovf, 1'b1);
        for (int i = csr_pkg::STACK_DEPTH - 1; i >= 0; i--)
        begin
            acc(0, 0, csr_pkg::MAIN_STACK_PORT, 8'h00);
            chk(rd, 8'(i));
        end
        acc(0, 0, csr_pkg::MAIN_STACK_PORT, 8'h00);
        chk(unf, 1'b1);
        $display("stack test done");
        @(posedge ref_clk) errorViewSelect <= 1'b1;
        pulse(11'h7C0);
        acc(0, 1, FIFO, 8'h00);
        chk(rd[4:0], 5'h1F);
        acc(0, 1, FIFO, 8'h00);
        chk(rd[4:0], 5'h00);
        pulse(11'h7C0);
        @(posedge ref_clk) linkResetControl <= 1'b1;
        #1 chk(linkReset, 1'b1);
        @(posedge ref_clk) linkResetControl <= 1'b0;
        acc(0, 1, FIFO, 8'h00);
        chk(rd[4:0], 5'h00);
        @(posedge ref_clk) rxWordsHeld <= 2'h2;
        rxDuringTxEnable <= 1'b1;
        pulse(11'h440);
        acc(0, 1, FIFO, 8'h00);
        chk(rd[4:0], 5'h00);
        @(posedge ref_clk) errorViewSelect <= 1'b0;
        acc(0, 1, FIFO, 8'h00);
        chk(rd, 8'h5A);
        $display("receive error test done");
        pulse(11'h002);
        repeat (12) @(posedge ref_clk);
        acc(0, 0, CND, 8'h00);
        chk(rd[6:5], 2'b10);
        @(posedge ref_clk) holdCycles <= 4'h9;
        pulse(11'h001);
        repeat (20) @(posedge ref_clk);
        acc(1, 0, CND, 8'h40);
        acc(0, 0, CND, 8'h00);
        chk(rd[6:5], 2'b01);
        acc(1, 0, CND, 8'h20);
        @(posedge ref_clk) remoteCfgDataMem <= 1'b0;
        pulse(11'h003);
        repeat (20) @(posedge ref_clk);
        acc(0, 0, CND, 8'h00);
        chk(rd[6:5], 2'b00);
        pulse(11'h01C);
        acc(0, 0, CND, 8'h00);
        chk(rd[3:0], 4'hE);
        @(posedge ref_clk)
            {aluNegative, aluZero, aluOverflow, aluCarry} <= 4'h4;
        pulse(11'h01C);
        @(posedge ref_clk) sharedIrqPinIn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        acc(0, 0, CND, 8'h00);
        chk(rd[4:0], 5'h01);
        pulse(11'h020);
        acc(0, 0, CND, 8'h00);
        chk(rd[4], 1'b1);
        $display("flags test done");
        results();
    end

    initial
    begin
        repeat (6000) @(posedge ref_clk);
        mismatches++;
        results();
    end
endmodule
